// ---- verilog/posl_cfg.svh ----
// constants for the power-on strap loader
// assumes a 50 MHz clock and a 6-bit external converter code
`ifndef POSL_CFG_SVH
`define POSL_CFG_SVH
`define POSL_CLK_MHZ        50
`define POSL_READY_MAX_US   2500
`define POSL_READY_CYCLES   (`POSL_READY_MAX_US * `POSL_CLK_MHZ)
`define POSL_CODE_W         6
`define POSL_STRAP_N        4
`define POSL_PHASE_MAX      3
`define POSL_SETTLE_CYCLES  16
`define POSL_IDX_SET1       2'h0
`define POSL_IDX_SET2       2'h1
`define POSL_IDX_SET3       2'h2
`define POSL_IDX_THERM      2'h3
`endif

// ---- verilog/posl_pkg.sv ----
// types for the power-on strap loader
// assumes posl_cfg.svh is on the include path
`include "posl_cfg.svh"
package posl_pkg;
    typedef enum logic [2:0]
    {
        POSL_OFF      = 3'b000,
        POSL_WAIT_ON  = 3'b001,
        POSL_OFFSET   = 3'b010,
        POSL_DIVIDER  = 3'b011,
        POSL_CURRENT  = 3'b100,
        POSL_BOOTRAMP = 3'b101,
        POSL_READY    = 3'b110
    } posl_state_t;
    typedef logic [`POSL_CODE_W-1:0] posl_code_t;
endpackage : posl_pkg

// ---- verilog/posl_conv_step.sv ----
// one converter request/answer step, with a settle wait after the pin is selected
// assumes convDone comes from logic on the same clock
`timescale 1ns/10ps
`include "posl_cfg.svh"
module posl_conv_step
#(
    parameter int SETTLE = `POSL_SETTLE_CYCLES
)
(
    input  wire logic clk,       // system clock
    input  wire logic reset,     // synchronous reset
    input  wire logic start,     // one-cycle pulse: begin a step
    input  wire logic convDone,  // converter answer pulse
    output logic      convStart, // converter request pulse
    output logic      done       // one-cycle pulse: code is valid
);
    logic [7:0] settle;
    logic       busy;
    logic       waiting;

    assign done = waiting & convDone;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            settle    <= 8'h00;
            busy      <= 1'b0;
            waiting   <= 1'b0;
            convStart <= 1'b0;
        end
        else
        begin
            convStart <= 1'b0;
            if (start)
            begin
                busy   <= 1'b1;
                settle <= 8'(SETTLE);
            end
            else if (busy && settle != 8'h00)
                settle <= settle - 8'h01;
            else if (busy)
            begin
                busy      <= 1'b0;
                waiting   <= 1'b1;
                convStart <= 1'b1;
            end
            else if (done)
                waiting <= 1'b0;
        end
    end
endmodule : posl_conv_step

// ---- verilog/posl_loader.sv ----
// start-up sequencer and strap configuration loader
// assumes analog comparators and converter are outside; comparator levels are asynchronous, converter answers are on this clock
`timescale 1ns/10ps
`include "posl_cfg.svh"

module posl_loader
    import posl_pkg::*;
#(
    parameter int READY_CYCLES = `POSL_READY_CYCLES,
    parameter int PHASES       = `POSL_PHASE_MAX
)
(
    input  wire logic               clk,              // 50 MHz clock
    input  wire logic               reset,            // synchronous, active high
    input  wire logic               supplyLowLockout, // supply below lockout, async
    input  wire logic               supplyAboveGood,  // supply above good threshold, async
    input  wire logic               vrOnRequest,      // external on request, async
    input  wire logic [PHASES-1:0]  phaseSenseNegHigh,// per-phase sense above supply-0.7V
    input  wire logic               noiseSuppressPin, // noise suppress pin level, async
    input  wire logic               offsetCalDone,    // offset correction finished
    input  wire logic               rampDone,         // boot ramp finished
    input  wire logic               convDone,         // converter answer pulse
    input  wire posl_pkg::posl_code_t convCode,       // converter code
    output logic                    convStart,        // converter request pulse
    output logic [1:0]              strapSelect,      // strap pin under conversion
    output logic                    currentSourceOn,  // 80 uA source into strap pin
    output logic                    offsetCalStart,   // offset correction request
    output logic                    bootRampStart,    // start ramp to boot voltage
    output logic                    supplyGood,       // internal supply good flag
    output logic                    chipEnable,       // controller enabled
    output logic                    highSideEnable,   // high-side switch allowed
    output logic                    lowSideEnable,    // low-side switch allowed
    output logic                    regulatorReady,   // ready for voltage commands
    output logic                    readyTimeout,     // ready missed its deadline
    output logic [1:0]              maxPhases,        // latched phase count
    output logic [3:0]              maxCurrentLimit,  // strap 1 current limit
    output logic [3:0]              onTimeSelect,     // strap 1 on-time
    output logic                    bootVoltageSelect,// 0: 0 V, 1: 1.8 V
    output logic [2:0]              overshootGuardThreshold, // strap 2
    output logic [1:0]              currentGain,      // strap 2
    output logic                    fastRampRate,     // strap 2, 0: 48 mV/us
    output logic                    noiseSuppressEnable, // strap 2 with pin
    output logic [1:0]              hfLoadlineLift,   // strap 2
    output logic [2:0]              quickResponseThreshold, // strap 3
    output logic [1:0]              zeroCrossThreshold, // strap 3
    output logic                    totalOvercurrentRatio, // 0: 160%, 1: 130%
    output logic [2:0]              undershootSuppress, // strap 3
    output logic                    rampLevelLowPower,// thermal strap
    output logic [1:0]              rampLevel,        // thermal strap
    output logic                    flatLoadlineEnable, // thermal strap
    output logic                    rampCompSink      // thermal strap
);
    // ==========================================================
    // input synchronisers
    logic [1:0]        syncLow;
    logic [1:0]        syncGood;
    logic [1:0]        syncOn;
    logic [1:0]        syncPin;
    logic [PHASES-1:0] syncPh0;
    logic [PHASES-1:0] syncPh1;
    always_ff @(posedge clk)
    begin
        syncLow  <= {syncLow[0], supplyLowLockout};
        syncGood <= {syncGood[0], supplyAboveGood};
        syncOn   <= {syncOn[0], vrOnRequest};
        syncPin  <= {syncPin[0], noiseSuppressPin};
        syncPh0  <= phaseSenseNegHigh;
        syncPh1  <= syncPh0;
    end
    wire lowS  = syncLow[1];
    wire goodS = syncGood[1] & ~lowS;
    wire onS   = syncOn[1];

    // ==========================================================
    // sequencer
    posl_state_t state;
    posl_state_t next_state;
    posl_code_t  divCode [`POSL_STRAP_N];
    posl_code_t  ofsCode [`POSL_STRAP_N];
    logic [31:0] readyCount;
    logic        stepStart;
    logic        stepDone;
    logic [1:0]  next_maxPhases;

    posl_conv_step u_step
    (
        .clk       (clk),
        .reset     (reset),
        .start     (stepStart),
        .convDone  (convDone),
        .convStart (convStart),
        .done      (stepDone)
    );

    wire enableOk   = goodS & onS;
    wire lastStrap  = (strapSelect == `POSL_IDX_THERM);
    // thermal strap uses only the divider step, so the current step stops before it
    wire lastOffset   = (strapSelect == `POSL_IDX_SET3);
    wire entering     = (state == POSL_WAIT_ON) && enableOk;
    wire calFinished  = (state == POSL_OFFSET) && (next_state == POSL_DIVIDER);
    wire divStore     = stepDone && (state == POSL_DIVIDER);
    wire ofsStore     = stepDone && (state == POSL_CURRENT);
    wire leaving      = (next_state <= POSL_WAIT_ON);
    wire rampEntry    = (next_state == POSL_BOOTRAMP) && (state != POSL_BOOTRAMP);
    // a done level left from an earlier ramp is still up while the new request is out,
    // so it only counts once the request pulse is gone
    wire rampFinished = rampDone && !bootRampStart;
    wire deadlineHit  = chipEnable && !regulatorReady && (readyCount >= 32'(READY_CYCLES));
    wire bootVoltageSelectNext = (strapSelect == `POSL_IDX_SET1 && stepDone)
                                 ? convCode[1] : ofsCode[`POSL_IDX_SET1][1];

    // lowest phase above phase 0 whose sense is high caps the count at that index
    always_comb
    begin
        next_maxPhases = 2'(PHASES);
        for (int i = PHASES - 1; i >= 1; i--)
            if (syncPh1[i])
                next_maxPhases = 2'(i);
    end

    always_comb
    begin
        next_state = state;
        case (state)
            POSL_OFF:      if (goodS) next_state = POSL_WAIT_ON;
            POSL_WAIT_ON:  if (enableOk) next_state = POSL_OFFSET;
            POSL_OFFSET:   if (offsetCalDone) next_state = POSL_DIVIDER;
            POSL_DIVIDER:  if (stepDone && lastStrap) next_state = POSL_CURRENT;
            POSL_CURRENT:  if (stepDone && lastOffset)
                               next_state = bootVoltageSelectNext ? POSL_BOOTRAMP
                                                                  : POSL_READY;
            POSL_BOOTRAMP: if (rampFinished) next_state = POSL_READY;
            POSL_READY:    next_state = POSL_READY;
            default:       next_state = POSL_OFF;
        endcase
        if (state != POSL_OFF && !goodS)
            next_state = POSL_OFF;
        else if (state > POSL_WAIT_ON && !onS)
            next_state = POSL_WAIT_ON;
    end

    // ==========================================================
    // state, strap pointer and request pulses
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state           <= POSL_OFF;
            strapSelect     <= `POSL_IDX_SET1;
            currentSourceOn <= 1'b0;
            offsetCalStart  <= 1'b0;
            bootRampStart   <= 1'b0;
            stepStart       <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            offsetCalStart <= entering;
            bootRampStart  <= rampEntry;
            stepStart      <= 1'b0;
            if (calFinished)
            begin
                strapSelect <= `POSL_IDX_SET1;
                stepStart   <= 1'b1;
            end
            if (divStore)
            begin
                strapSelect     <= lastStrap ? `POSL_IDX_SET1 : strapSelect + 2'h1;
                currentSourceOn <= lastStrap;
                stepStart       <= next_state == state || lastStrap;
            end
            if (ofsStore)
            begin
                strapSelect     <= strapSelect + 2'h1;
                currentSourceOn <= !lastOffset;
                stepStart       <= !lastOffset;
            end
            if (leaving)
            begin
                currentSourceOn <= 1'b0;
                stepStart       <= 1'b0;
            end
        end
    end

    // ==========================================================
    // converter codes, rewritten by every readout
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < `POSL_STRAP_N; i++)
            begin
                divCode[i] <= '0;
                ofsCode[i] <= '0;
            end
        end
        else if (divStore)
            divCode[strapSelect] <= convCode;
        else if (ofsStore)
            ofsCode[strapSelect] <= convCode;
    end

    // ==========================================================
    // phase count latch
    always_ff @(posedge clk)
    begin
        if (reset)
            maxPhases <= 2'(PHASES);
        else if (entering)
            maxPhases <= next_maxPhases;
    end

    // ==========================================================
    // ready deadline
    // the counter only flags a late ready; it cannot hurry the readout along
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            readyCount   <= 32'h0;
            readyTimeout <= 1'b0;
        end
        else
        begin
            if (!chipEnable)
                readyCount <= 32'h0;
            else if (!regulatorReady && !deadlineHit)
                readyCount <= readyCount + 32'h1;
            readyTimeout <= deadlineHit;
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            supplyGood     <= 1'b0;
            chipEnable     <= 1'b0;
            highSideEnable <= 1'b0;
            lowSideEnable  <= 1'b0;
            regulatorReady <= 1'b0;
            noiseSuppressEnable <= 1'b0;
        end
        else
        begin
            supplyGood     <= goodS;
            chipEnable     <= next_state > POSL_WAIT_ON;
            highSideEnable <= !lowS && next_state == POSL_READY;
            lowSideEnable  <= !lowS && next_state == POSL_READY;
            regulatorReady <= next_state == POSL_READY;
            noiseSuppressEnable <= ofsCode[`POSL_IDX_SET2][3] & syncPin[1];
        end
    end

    // ==========================================================
    // strap 1 fields
    // decoded fields stay put until the next readout rewrites the codes
    assign maxCurrentLimit         = divCode[`POSL_IDX_SET1][3:0];
    assign onTimeSelect            = {divCode[`POSL_IDX_SET1][4],
                                      ofsCode[`POSL_IDX_SET1][4:2]};
    assign bootVoltageSelect       = ofsCode[`POSL_IDX_SET1][1];

    // ==========================================================
    // strap 2 fields
    assign overshootGuardThreshold = divCode[`POSL_IDX_SET2][4:2];
    assign currentGain             = divCode[`POSL_IDX_SET2][1:0];
    assign fastRampRate            = ofsCode[`POSL_IDX_SET2][4];
    assign hfLoadlineLift          = ofsCode[`POSL_IDX_SET2][2:1];

    // ==========================================================
    // strap 3 fields
    assign quickResponseThreshold  = divCode[`POSL_IDX_SET3][4:2];
    assign zeroCrossThreshold      = divCode[`POSL_IDX_SET3][1:0];
    assign totalOvercurrentRatio   = ofsCode[`POSL_IDX_SET3][4];
    assign undershootSuppress      = ofsCode[`POSL_IDX_SET3][3:1];

    // ==========================================================
    // thermal strap fields, divider step only
    assign rampLevelLowPower       = divCode[`POSL_IDX_THERM][5];
    assign rampLevel               = divCode[`POSL_IDX_THERM][4:3];
    assign flatLoadlineEnable      = divCode[`POSL_IDX_THERM][2];
    assign rampCompSink            = divCode[`POSL_IDX_THERM][1];
endmodule : posl_loader

// ---- dv/posl_loader_props.sv ----
// checker for the strap loader start-up and readout behaviour
// assumes it is bound to posl_loader and sees its ports only
`timescale 1ns/10ps
module posl_loader_props
#(
    parameter int READY_CYCLES = 2000
)
(
    input wire logic       clk,               // clock
    input wire logic       reset,             // sync reset
    input wire logic       supplyLowLockout,  // lockout level
    input wire logic       rampDone,          // ramp finished
    input wire logic       offsetCalStart,    // cal request
    input wire logic       bootRampStart,     // ramp request
    input wire logic       convStart,         // converter request
    input wire logic [1:0] strapSelect,       // pin under conversion
    input wire logic       currentSourceOn,   // current source
    input wire logic       supplyGood,        // supply flag
    input wire logic       chipEnable,        // enable
    input wire logic       highSideEnable,    // high switch
    input wire logic       lowSideEnable,     // low switch
    input wire logic       regulatorReady,    // ready
    input wire logic [1:0] maxPhases,         // phase count
    input wire logic       bootVoltageSelect, // boot select
    input wire logic [3:0] maxCurrentLimit    // current limit
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // helper counters
    int   readyWait;
    logic rampSeen;
    always_ff @(posedge clk)
    begin
        readyWait <= (reset || !chipEnable || regulatorReady) ? 0 : readyWait + 1;
        // a stale done level is wiped by the ramp request itself
        rampSeen  <= (reset || !chipEnable || bootRampStart) ? 1'b0 : (rampSeen | rampDone);
    end
    // ==========================================
    // properties
    sequence s_enable_rise; $rose(chipEnable); endsequence
    sequence s_cal_follows; ##[0:2] offsetCalStart; endsequence
    property p_lockout_off;
        supplyLowLockout[*5] |-> !chipEnable && !highSideEnable && !lowSideEnable && !regulatorReady;
    endproperty
    property p_enable_needs_good; s_enable_rise |-> supplyGood; endproperty
    property p_cal_first; s_enable_rise |-> s_cal_follows; endproperty
    property p_ready_needs_enable; regulatorReady |-> chipEnable; endproperty
    property p_ready_after_ramp; $rose(regulatorReady) && bootVoltageSelect |-> rampSeen; endproperty
    property p_ready_deadline; readyWait <= READY_CYCLES; endproperty
    property p_phase_held; chipEnable[*3] |-> $stable(maxPhases); endproperty
    property p_thermal_no_current; convStart && strapSelect == 2'h3 |-> !currentSourceOn; endproperty
    property p_fields_held; regulatorReady && $past(regulatorReady) |-> $stable(maxCurrentLimit); endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("lockout left outputs on");
    a_enable_needs_good: assert property (p_enable_needs_good) else $error("enable without good");
    a_cal_first: assert property (p_cal_first) else $error("no offset cal after enable");
    a_ready_needs_enable: assert property (p_ready_needs_enable) else $error("ready while off");
    a_ready_after_ramp: assert property (p_ready_after_ramp) else $error("ready before ramp");
    a_ready_deadline: assert property (p_ready_deadline) else $error("ready too late");
    a_phase_held: assert property (p_phase_held) else $error("phase count moved");
    a_thermal_no_current: assert property (p_thermal_no_current) else $error("thermal offset step");
    a_fields_held: assert property (p_fields_held) else $error("field moved while ready");
endmodule : posl_loader_props
bind posl_loader posl_loader_props #(.READY_CYCLES(READY_CYCLES)) props_u (.*);

// ---- dv/posl_strap_model.sv ----
// model of the converter, offset calibration and boot ramp beside the loader
// assumes codes are given per strap pin, six bits each, lowest pin lowest
`timescale 1ns/10ps
module posl_strap_model
    import posl_pkg::*;
(
    input wire logic        clk,             // clock
    input wire logic        reset,           // sync reset
    input wire logic        convStart,       // converter request
    input wire logic [1:0]  strapSelect,     // pin selected
    input wire logic        currentSourceOn, // offset step
    input wire logic        offsetCalStart,  // cal request
    input wire logic        bootRampStart,   // ramp request
    input wire logic        slow,            // slow answers
    input wire logic [23:0] divCodes,        // divider codes
    input wire logic [23:0] offCodes,        // offset codes
    output logic            convDone,        // answer pulse
    output posl_pkg::posl_code_t convCode,   // answer code
    output logic            offsetCalDone,   // cal done pulse
    output logic            rampDone         // ramp done level
);
    logic [3:0] convCnt, calCnt;
    logic [5:0] rampCnt;
    logic [1:0] sel;
    logic       cur;
    posl_code_t answer;
    // code is only good with its pulse; otherwise show its inverse
    assign convCode = convDone ? answer : ~answer;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            convCnt <= 4'h0; calCnt <= 4'h0; rampCnt <= 6'h00; answer <= 6'h00;
            convDone <= 1'b0; offsetCalDone <= 1'b0; rampDone <= 1'b0;
        end
        else
        begin
            convDone <= convCnt == 4'h1;
            offsetCalDone <= calCnt == 4'h1;
            if (convStart)
            begin
                convCnt <= slow ? 4'h9 : 4'h1;
                sel <= strapSelect;
                cur <= currentSourceOn;
            end
            else if (convCnt != 4'h0) convCnt <= convCnt - 4'h1;
            if (convCnt == 4'h1) answer <= cur ? offCodes[sel*6+:6] : divCodes[sel*6+:6];
            calCnt <= offsetCalStart ? 4'h4 : (calCnt != 4'h0 ? calCnt - 4'h1 : 4'h0);
            if (bootRampStart)
            begin
                rampDone <= 1'b0;
                rampCnt <= slow ? 6'h28 : 6'h05;
            end
            else if (rampCnt != 6'h00)
            begin
                rampCnt <= rampCnt - 6'h01;
                rampDone <= rampCnt == 6'h01;
            end
        end
    end
endmodule : posl_strap_model

// ---- dv/posl_loader_test.sv ----
// self-checking bench for the strap loader
// assumes posl_strap_model answers the converter, calibration and ramp
`timescale 1ns/10ps
module posl_loader_test;
    import posl_pkg::*;
    logic clk = 0, reset = 1, supplyLowLockout = 0, supplyAboveGood = 0, vrOnRequest = 0;
    logic noiseSuppressPin = 0, slow = 0;
    logic [2:0] phaseSenseNegHigh = 3'h0;
    logic [23:0] divCodes = 24'h0, offCodes = 24'h0;
    logic offsetCalDone, rampDone, convDone, convStart, currentSourceOn, offsetCalStart;
    logic bootRampStart, supplyGood, chipEnable, highSideEnable, lowSideEnable, regulatorReady;
    logic readyTimeout, bootVoltageSelect, fastRampRate, noiseSuppressEnable;
    logic totalOvercurrentRatio, rampLevelLowPower, flatLoadlineEnable, rampCompSink;
    posl_code_t convCode;
    logic [1:0] strapSelect, maxPhases, currentGain, hfLoadlineLift, zeroCrossThreshold, rampLevel;
    logic [2:0] overshootGuardThreshold, quickResponseThreshold, undershootSuppress;
    logic [3:0] maxCurrentLimit, onTimeSelect;
    int err_count = 0, num_checks = 0;
    posl_loader #(.READY_CYCLES(2000)) dut_u (.*);
    posl_strap_model model_u (.*);
    always #10 clk = ~clk;
    // ==========================================
    // tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task conclude;
        if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task wait_ready;
        int i;
        for (i = 0; i < 3000 && regulatorReady !== 1'b1; i++) cyc(1);
        if (i == 3000)
        begin
            err_count++;
            $display("mismatch at %0t: ready never came", $time);
            conclude();
        end
    endtask : wait_ready
    function logic [31:0] fields(input logic [23:0] d, input logic [23:0] o, input logic p);
        fields = {d[3:0], d[4], o[4:2], o[1], d[10:8], d[7:6], o[10], o[9] & p, o[8:7],
                  d[16:14], d[13:12], o[16], o[15:13], d[23], d[22:21], d[20], d[19]};
    endfunction : fields
    task run(input logic [23:0] d, input logic [23:0] o);
        divCodes = d;
        offCodes = o;
        cyc(1);
        vrOnRequest = 1;
        wait_ready();
        check({chipEnable, highSideEnable, lowSideEnable, readyTimeout}, 32'hE);
        check({maxCurrentLimit, onTimeSelect, bootVoltageSelect, overshootGuardThreshold,
               currentGain, fastRampRate, noiseSuppressEnable, hfLoadlineLift,
               quickResponseThreshold, zeroCrossThreshold, totalOvercurrentRatio,
               undershootSuppress, rampLevelLowPower, rampLevel, flatLoadlineEnable,
               rampCompSink}, fields(d, o, noiseSuppressPin));
    endtask : run
    // ==========================================
    // sequence
    initial
    begin
        cyc(12);
        reset = 0;
        cyc(2);
        supplyAboveGood = 1;
        phaseSenseNegHigh = 3'h4;
        noiseSuppressPin = 1;
        cyc(8);
        check({supplyGood, chipEnable}, 32'h2);
        run(24'h9A5C3E, 24'h5B6A1C);
        check(maxPhases, 32'h2);
        phaseSenseNegHigh = 3'h2;
        cyc(6);
        check(maxPhases, 32'h2);
        vrOnRequest = 0;
        cyc(8);
        check({chipEnable, regulatorReady}, 32'h0);
        slow = 1;
        noiseSuppressPin = 0;
        run(24'h65A3C1, 24'hA495E3);
        check(maxPhases, 32'h1);
        supplyLowLockout = 1;
        cyc(8);
        check({chipEnable, highSideEnable, lowSideEnable, regulatorReady}, 32'h0);
        phaseSenseNegHigh = 3'h0;
        supplyLowLockout = 0;
        wait_ready();
        check(maxPhases, 32'h3);
        conclude();
    end
endmodule : posl_loader_test
